/* rximm_detect.sv */
// Purpose: Per-source edge or level detection with sticky pending bits.
// Assumes: Source levels are already synchronised to ref_clk.
// Notes:   Reserved trigger code raises nothing.
`timescale 1ns/1ps
module rximm_detect (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [8:0] src_level,
    rximm_if.det            port
);
    logic [8:0] prev_reg;
    logic [8:0] hit;

    // Detection of the chosen trigger for one source.
    function automatic logic rximm_trig_hit(input logic [1:0] mode, input logic cur, input logic old);
        logic r;
        r = 1'b0;
        unique case (mode)
            rximm_pkg::RXIMM_TRIG_RISE:  r = cur & ~old;
            rximm_pkg::RXIMM_TRIG_FALL:  r = ~cur & old;
            rximm_pkg::RXIMM_TRIG_LEVEL: r = cur;
            rximm_pkg::RXIMM_TRIG_RSVD:  r = 1'b0;
        endcase
        return r;
    endfunction : rximm_trig_hit

    // Masked sources never qualify, so they cannot raise a pending bit.
    always_comb
    begin
        for (int i = 0; i < rximm_pkg::RXIMM_SRC_N; i++)
        begin
            hit[i] = port.enable[i] & rximm_trig_hit(port.trig_mode[2*i +: 2], src_level[i], prev_reg[i]);
        end
    end

    // Previous level for edge detection.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            prev_reg <= 9'h000;
        else
            prev_reg <= src_level;
    end

    // Sticky pending; a new hit wins over a same-cycle acknowledge.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            port.pending <= 9'h000;
        else
            port.pending <= (port.pending & ~port.ack) | hit;
    end

    AST_MASKED_NO_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!port.enable[3] && !port.pending[3]) |=> !port.pending[3])
        else $error("masked change source set pending");
    AST_RISE_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port.enable[2] && port.trig_mode[5:4] == rximm_pkg::RXIMM_TRIG_RISE && src_level[2] && !prev_reg[2])
        |=> port.pending[2])
        else $error("rising edge missed on lock loss");
    AST_FALL_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port.enable[7] && port.trig_mode[15:14] == rximm_pkg::RXIMM_TRIG_FALL && !src_level[7] && prev_reg[7])
        |=> port.pending[7])
        else $error("falling edge missed on status crc");
    AST_LEVEL_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port.enable[4] && port.trig_mode[9:8] == rximm_pkg::RXIMM_TRIG_LEVEL && src_level[4])
        |=> port.pending[4])
        else $error("level trigger missed on line code");
    AST_RSVD_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port.trig_mode[1:0] == rximm_pkg::RXIMM_TRIG_RSVD && !port.pending[0]) |=> !port.pending[0])
        else $error("reserved mode raised buffer copy");
    COV_LEVEL: cover property (@(posedge ref_clk) disable iff (!rst_n)
        port.trig_mode[9:8] == rximm_pkg::RXIMM_TRIG_LEVEL && hit[4]);
    COV_FALL: cover property (@(posedge ref_clk) disable iff (!rst_n) hit[7] && !src_level[7]);
endmodule : rximm_detect

/* rximm_if.sv */
// Purpose: Carrier between the register file and the trigger detector.
// Assumes: One clock domain.
// Notes:   Mode codes are two bits per source, source order as in the package.
`timescale 1ns/1ps
interface rximm_if;
    logic [17:0] trig_mode;
    logic [8:0]  enable;
    logic [8:0]  pending;
    logic [8:0]  ack;
    modport ctrl (output trig_mode, output enable, output ack, input pending);
    modport det  (input trig_mode, input enable, input ack, output pending);
endinterface : rximm_if

/* rximm_pkg.sv */
// Purpose: Shared constants for the receiver interrupt mask and trigger-mode block.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses four times the register index.
// Notes:   Eight-bit registers sit in the low bits of each word; upper bits read as zero.
package rximm_pkg;
    // Register indices as printed, and the address width they are decoded within.
    localparam logic [7:0] RXIMM_IDX_ENABLE_ONE  = 8'h16;
    localparam logic [7:0] RXIMM_IDX_ENABLE_TWO  = 8'h17;
    localparam logic [7:0] RXIMM_IDX_TRIG_ONE    = 8'h18;
    localparam logic [7:0] RXIMM_IDX_TRIG_TWO    = 8'h19;
    localparam logic [7:0] RXIMM_IDX_SOURCE      = 8'h1E;
    localparam logic [7:0] RXIMM_IDX_PENDING     = 8'h1F;
    localparam int         RXIMM_ADDR_W          = 10;

    // Reset values: every source masked, every trigger rising-edge.
    localparam logic [7:0] RXIMM_RST_ENABLE_ONE  = 8'h00;
    localparam logic [7:0] RXIMM_RST_ENABLE_TWO  = 8'h00;
    localparam logic [7:0] RXIMM_RST_TRIG        = 8'h00;
    localparam logic [7:0] RXIMM_ENABLE_TWO_MASK = 8'h01;

    // Source bit positions inside the nine-bit source vector.
    localparam int RXIMM_SRC_N        = 9;
    localparam int RXIMM_BIT_BUFCOPY  = 0;
    localparam int RXIMM_BIT_SUBCRC   = 1;
    localparam int RXIMM_BIT_LOCKLOSS = 2;
    localparam int RXIMM_BIT_SUBCHG   = 3;
    localparam int RXIMM_BIT_LINECODE = 4;
    localparam int RXIMM_BIT_VALIDITY = 5;
    localparam int RXIMM_BIT_FRAMECHK = 6;
    localparam int RXIMM_BIT_CSCRC    = 7;
    localparam int RXIMM_BIT_SLIP     = 8;

    // Two-bit trigger encoding.
    localparam logic [1:0] RXIMM_TRIG_RISE  = 2'h0;
    localparam logic [1:0] RXIMM_TRIG_FALL  = 2'h1;
    localparam logic [1:0] RXIMM_TRIG_LEVEL = 2'h2;
    localparam logic [1:0] RXIMM_TRIG_RSVD  = 2'h3;

    localparam logic [1:0] RXIMM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RXIMM_RESP_SLVERR = 2'h2;
endpackage : rximm_pkg

/* rximm_tb_top.sv */
// Purpose: Self-checking bench for the receiver interrupt enable and trigger block.
// Assumes: AXI4-Lite master here, flags driven directly, byte address four times the index.
// Notes:   An integer model predicts the pin for every case and the pending word when the source is enabled.
`timescale 1ns/1ps
module rximm_tb_top;
    localparam logic [31:0] A_EN1  = {22'h0, rximm_pkg::RXIMM_IDX_ENABLE_ONE, 2'h0};
    localparam logic [31:0] A_EN2  = {22'h0, rximm_pkg::RXIMM_IDX_ENABLE_TWO, 2'h0};
    localparam logic [31:0] A_TR1  = {22'h0, rximm_pkg::RXIMM_IDX_TRIG_ONE, 2'h0};
    localparam logic [31:0] A_TR2  = {22'h0, rximm_pkg::RXIMM_IDX_TRIG_TWO, 2'h0};
    localparam logic [31:0] A_PEND = {22'h0, rximm_pkg::RXIMM_IDX_PENDING, 2'h0};
    logic        ref_clk, rst_n, gpo_carries_irq, rx_irq_n;
    logic [8:0]  flag_in;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          fail_count;
    int          checks_done;
    logic [31:0] rng;

    rximm_top u_rximm_top (.ref_clk(ref_clk), .rst_n(rst_n), .flag_in(flag_in),
        .gpo_carries_irq(gpo_carries_irq), .rx_irq_n(rx_irq_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // Free-running 125 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Xorshift generator; a fixed start keeps every run identical.
    function automatic logic [31:0] rand32();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rand32

    // Verdict and end of run, reached from the main sequence or a timeout.
    task give_verdict();
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task timeout();
        fail_count++;
        give_verdict();
    endtask : timeout

    task note(input bit bad, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (bad)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : note

    task cmp_word(input logic [31:0] g, input logic [31:0] e);
        note(g !== e, g, e);
    endtask : cmp_word

    task cmp_resp(input logic [1:0] g, input logic [1:0] e);
        note(g !== e, {30'h0, g}, {30'h0, e});
    endtask : cmp_resp

    task cmp_pin(input logic g, input logic e);
        note(g !== e, {31'h0, g}, {31'h0, e});
    endtask : cmp_pin

    // Address and data offered together; each is dropped at the edge that takes it.
    task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 64)
            timeout();
    endtask : axi_write

    task axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 64)
            timeout();
    endtask : axi_read

    // Main sequence: reset values, register quirks, then every source in every legal mode.
    initial
    begin
        int          s, m, k;
        logic [31:0] v, d;
        logic [7:0]  t1, t2;
        logic [8:0]  e;
        logic [1:0]  resp;
        logic        st, ed, en_b, gpo_b, hit;
        {fail_count, checks_done, rng} = {32'h0, 32'h0, 32'h0001_7883};
        {rst_n, flag_in, gpo_carries_irq} = 11'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        axi_read(A_EN1, d, resp);
        cmp_word(d, 32'h0);
        axi_read(A_EN2, d, resp);
        cmp_word(d, 32'h0);
        axi_read(A_TR1, d, resp);
        cmp_word(d, 32'h0);
        axi_read(A_TR2, d, resp);
        cmp_word(d, 32'h0);
        axi_write(A_EN2, 32'hFFFF_FFFF, 4'hF, resp);
        axi_read(A_EN2, d, resp);
        cmp_word(d, 32'h1);
        // Low byte strobe off: the enable must stay masked.
        axi_write(A_EN1, 32'hFF, 4'hE, resp);
        axi_read(A_EN1, d, resp);
        cmp_word(d, 32'h0);
        axi_write(32'h40, 32'hFF, 4'hF, resp);
        cmp_resp(resp, rximm_pkg::RXIMM_RESP_SLVERR);
        axi_read(32'h40, d, resp);
        cmp_resp(resp, rximm_pkg::RXIMM_RESP_SLVERR);
        for (s = 0; s < 9; s++)
            for (m = 0; m < 3; m++)
                for (k = 0; k < 2; k++)
                begin
                    if (s == 8 && m != 0)
                        continue;
                    v     = rand32();
                    st    = v[3];
                    ed    = (k == 0) ? !st : v[4];
                    en_b  = (k == 0) | v[1];
                    gpo_b = (k == 0) | v[2];
                    // Other fields never get the reserved code.
                    t1 = (v[15:8] & 8'h55) | (v[15:8] & ~(v[15:8] << 1) & 8'hAA);
                    t2 = (v[23:16] & 8'h55) | (v[23:16] & ~(v[23:16] << 1) & 8'hAA);
                    if (s < 4)
                        t1[2*s +: 2] = 2'(m);
                    else if (s < 8)
                        t2[2*(s-4) +: 2] = 2'(m);
                    e    = v[31:23];
                    e[s] = en_b;
                    flag_in <= 9'(st) << s;
                    repeat (6) @(posedge ref_clk);
                    axi_write(A_TR1, {24'h0, t1}, 4'hF, resp);
                    axi_write(A_TR2, {24'h0, t2}, 4'hF, resp);
                    axi_write(A_EN1, {24'h0, e[7:0]}, 4'hF, resp);
                    axi_write(A_EN2, {31'h0, e[8]}, 4'hF, resp);
                    axi_write(A_PEND, 32'h1FF, 4'hF, resp);
                    axi_read(A_TR1, d, resp);
                    cmp_word(d, {24'h0, t1});
                    axi_read(A_TR2, d, resp);
                    cmp_word(d, {24'h0, t2});
                    gpo_carries_irq <= gpo_b;
                    flag_in         <= 9'(ed) << s;
                    repeat (8) @(posedge ref_clk);
                    // Model of the trigger: rise, fall or level.
                    hit = (m == 0) ? (!st && ed) : (m == 1) ? (st && !ed) : (st || ed);
                    cmp_pin(rx_irq_n, !(hit && en_b && gpo_b));
                    if (en_b)
                    begin
                        axi_read(A_PEND, d, resp);
                        cmp_word(d, {23'h0, 9'(hit) << s});
                    end
                end
        // A second reset must mask everything again.
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        axi_read(A_EN1, d, resp);
        cmp_word(d, 32'h0);
        cmp_pin(rx_irq_n, 1'b1);
        give_verdict();
    end
endmodule : rximm_tb_top

/* rximm_top.sv */
// Purpose: Receiver interrupt enables and trigger modes behind an AXI4-Lite slave.
// Assumes: ref_clk at 125 MHz, synchronous active-low reset, asynchronous flag inputs.
// Notes:   Combined interrupt is driven active low when the general output is set to carry it.
// Notes on behaviour
// - Sub-code change interrupt gated by enable bit; 0 masks, 1 enables, reset masked.
// - Lock loss interrupt gated by enable bit, reset masked, 1 enables.
// - Sub-code CRC interrupt gated by enable bit, reset masked, 1 enables.
// - Buffer copy interrupt gated by enable bit, reset masked, 1 enables.
// - Slip enable is bit 0 of the second enable register; bits 7..1 read zero.
// - First trigger register: change, lock loss, sub-code CRC, buffer copy, high to low.
// - Change trigger: 00 rise default, 01 fall, 10 level, 11 reserved.
// - Lock loss trigger uses the same encoding, rise by default.
// - Sub-code CRC and buffer copy triggers use the same encoding.
// - Channel status CRC trigger uses the same encoding.
// - Line code error trigger uses the same encoding.
// - Only enabled sources raise an interrupt; masked flags stay silent.
// - Combined interrupt offered active low on a general output when configured.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rximm_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [8:0]  flag_in,
    input  wire logic        gpo_carries_irq,
    output logic             rx_irq_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    rximm_if link ();

    logic [8:0]  sync1_reg;
    logic [8:0]  sync2_reg;
    logic [7:0]  enable_one_reg;
    logic [7:0]  enable_two_reg;
    logic [7:0]  trig_one_reg;
    logic [7:0]  trig_two_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;
    logic        wr_hit;
    logic [7:0]  wr_idx;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_hit;
    logic [8:0]  ack_reg;
    logic        irq_reg;

    // Word address to printed register index; misaligned or far addresses never match.
    function automatic logic [7:0] rximm_index(input logic [31:0] addr);
        logic [7:0] idx;
        idx = 8'hFF;
        if (addr[1:0] == 2'h0 && addr[31:rximm_pkg::RXIMM_ADDR_W] == '0)
            idx = addr[9:2];
        return idx;
    endfunction : rximm_index

    // True when the index is one of the mapped registers.
    function automatic logic rximm_mapped(input logic [7:0] idx);
        return idx == rximm_pkg::RXIMM_IDX_ENABLE_ONE || idx == rximm_pkg::RXIMM_IDX_ENABLE_TWO
            || idx == rximm_pkg::RXIMM_IDX_TRIG_ONE || idx == rximm_pkg::RXIMM_IDX_TRIG_TWO
            || idx == rximm_pkg::RXIMM_IDX_SOURCE || idx == rximm_pkg::RXIMM_IDX_PENDING;
    endfunction : rximm_mapped

    // Flags come from other parts of the receiver on unrelated timing, so two stages first.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end
        else
        begin
            sync1_reg <= flag_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Address and data may arrive in either order; each is held until both are in.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    // A held half blocks a second one until the response has been taken.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_idx        = rximm_index(awaddr_reg);
    assign wr_hit        = do_write && rximm_mapped(wr_idx) && wstrb_reg[0];

    // Write response, one cycle after both halves are held.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rximm_pkg::RXIMM_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= rximm_mapped(wr_idx) ? rximm_pkg::RXIMM_RESP_OKAY : rximm_pkg::RXIMM_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Enable registers; everything comes out of reset masked.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            enable_one_reg <= rximm_pkg::RXIMM_RST_ENABLE_ONE;
            enable_two_reg <= rximm_pkg::RXIMM_RST_ENABLE_TWO;
        end
        else if (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_ENABLE_ONE)
            enable_one_reg <= wdata_reg[7:0];
        else if (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_ENABLE_TWO)
            enable_two_reg <= wdata_reg[7:0] & rximm_pkg::RXIMM_ENABLE_TWO_MASK;
    end

    // Trigger registers; the reserved code is stored as written and then detects nothing.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trig_one_reg <= rximm_pkg::RXIMM_RST_TRIG;
            trig_two_reg <= rximm_pkg::RXIMM_RST_TRIG;
        end
        else if (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_TRIG_ONE)
            trig_one_reg <= wdata_reg[7:0];
        else if (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_TRIG_TWO)
            trig_two_reg <= wdata_reg[7:0];
    end

    // Writing ones to the pending register acknowledges those bits for one cycle.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ack_reg <= 9'h000;
        else if (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_PENDING)
            ack_reg <= wdata_reg[8:0];
        else
            ack_reg <= 9'h000;
    end

    // Field order of each register follows the source vector order, low bits first.
    assign link.trig_mode = {2'h0, trig_two_reg, trig_one_reg};
    assign link.enable    = {enable_two_reg[0], enable_one_reg};
    assign link.ack       = ack_reg;

    rximm_detect u_detect (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .src_level (sync2_reg),
        .port      (link)
    );

    // The slip source has no trigger field here; its mode bits are tied to rising edge.
    // Combined interrupt: any pending bit, shown low only when the output is configured.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= |link.pending;
    end
    assign rx_irq_n = !(irq_reg && gpo_carries_irq);

    // Read path; answer one cycle after the address is taken.
    assign rd_idx        = rximm_index(s_axi_araddr);
    assign rd_hit        = rximm_mapped(rd_idx);
    assign s_axi_arready = !s_axi_rvalid;
    always_comb
    begin
        rd_byte = 8'h00;
        if (rd_idx == rximm_pkg::RXIMM_IDX_ENABLE_ONE)
            rd_byte = enable_one_reg;
        else if (rd_idx == rximm_pkg::RXIMM_IDX_ENABLE_TWO)
            rd_byte = enable_two_reg;
        else if (rd_idx == rximm_pkg::RXIMM_IDX_TRIG_ONE)
            rd_byte = trig_one_reg;
        else if (rd_idx == rximm_pkg::RXIMM_IDX_TRIG_TWO)
            rd_byte = trig_two_reg;
    end

    // Read data is registered so that the answer stands unchanged while rvalid waits.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= rximm_pkg::RXIMM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_hit ? rximm_pkg::RXIMM_RESP_OKAY : rximm_pkg::RXIMM_RESP_SLVERR;
            if (rd_idx == rximm_pkg::RXIMM_IDX_SOURCE)
                s_axi_rdata <= {23'h000000, sync2_reg};
            else if (rd_idx == rximm_pkg::RXIMM_IDX_PENDING)
                s_axi_rdata <= {23'h000000, link.pending};
            else
                s_axi_rdata <= {24'h000000, rd_byte};
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Register file: reset values, stored bits and writes that land.
    AST_RESET_MASKED: assert property (@(posedge ref_clk)
        !rst_n |=> (enable_one_reg == 8'h00 && enable_two_reg == 8'h00
            && trig_one_reg == 8'h00 && trig_two_reg == 8'h00))
        else $error("enables not masked after reset");

    AST_TWO_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_two_reg[7:1] == 7'h00)
        else $error("upper enable two bits not zero");

    AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_ENABLE_ONE)
        |=> enable_one_reg == $past(wdata_reg[7:0]))
        else $error("enable one write lost");

    AST_TRIG_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_TRIG_ONE)
        |=> trig_one_reg == $past(wdata_reg[7:0]))
        else $error("trigger one write lost");

    AST_TRIG_TWO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_hit && wr_idx == rximm_pkg::RXIMM_IDX_TRIG_TWO)
        |=> trig_two_reg == $past(wdata_reg[7:0]))
        else $error("trigger two write lost");

    AST_EN2_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && rd_idx == rximm_pkg::RXIMM_IDX_ENABLE_TWO)
        |=> s_axi_rdata[31:1] == 31'h0)
        else $error("enable two read upper bits not zero");

    // Masking: a clear enable bit keeps its pending bit low.
    AST_ENABLE_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!enable_one_reg[2] && !link.pending[2])
        |=> !link.pending[2])
        else $error("masked lock loss set pending");

    AST_CRC_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!enable_one_reg[1] && !link.pending[1]) ##1 !enable_one_reg[1]
        |-> !link.pending[1])
        else $error("masked crc set pending");

    AST_COPY_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!enable_one_reg[0] && !link.pending[0])
        |=> !link.pending[0])
        else $error("masked buffer copy set pending");

    AST_SLIP_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!enable_two_reg[0] && !link.pending[8])
        |=> !link.pending[8])
        else $error("masked slip set pending");

    // Combined interrupt: follows the pending word one cycle later.
    AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|link.pending)
        |=> irq_reg)
        else $error("irq did not follow pending");

    AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|link.pending)
        |=> !irq_reg)
        else $error("irq stayed set with nothing pending");

    AST_IRQ_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($rose(|link.pending) && gpo_carries_irq) ##1 gpo_carries_irq
        |-> !rx_irq_n)
        else $error("irq pin not low");

    AST_PIN_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !gpo_carries_irq |-> rx_irq_n)
        else $error("irq pin low while not configured");

    // Bus answers stand until the master takes them.
    AST_BRESP_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        do_write
        |=> s_axi_bvalid)
        else $error("no write response");

    AST_BVALID_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready)
        |=> s_axi_bvalid)
        else $error("write response dropped before taken");

    AST_RVALID_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_axi_rvalid && !s_axi_rready)
        |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read answer dropped before taken");

    // Main scenarios: a register write, a read taken, and the pin going low.
    COV_WRITE: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_hit);
    COV_READ: cover property (@(posedge ref_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
    COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(rx_irq_n));
endmodule : rximm_top
